/* logic/dfd_dispatch.sv */
// digital input filter, function dispatch and register slave
`timescale 1ns/100ps
// Operation
// - swing-pause terminal holds centre, halts swing
// - code 25 pulses advance event counter
// - code 26 clears event counter
// - code 27 counts length, 28 clears it
// - code 29 blocks torque control mode
// - pulse input only sixth; reserved codes inert
// - code 32 enters DC braking immediately
// - normally-closed code 33 opens: fault, stop
// - code 34 gates when new setpoint applies
// - code 35 inverts configured PID direction
// - code 36 stops like keypad key, only with keypad command source
// - code 37 swaps terminal and communication source
// - code 38 freezes PID integral only
// - codes 39/40 force preset frequency sources
// - code 43 selects second PID gains
// - codes 44/45 raise user faults
// - code 46 swaps speed and torque mode
// - code 47 triggers fastest emergency stop
// - code 48 stops anywhere using decel four
// - code 49 decelerates then DC brakes
// - code 50 clears running time accumulator
// - each input debounced by configurable filter

module dfd_input_filter
    import dfd_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // raw pin and timing
    input wire logic pin_i,
    input wire logic tick_i,
    input wire logic [FILT_W-1:0] filt_ms_i,
    // debounced level
    output logic level_o
);
    logic sync1_q;
    logic sync2_q;
    logic [FILT_W-1:0] ms_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // a level must stand unchanged for the whole filter time before it is taken
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ms_q <= '0;
            level_o <= 1'b0;
        end else if (sync2_q == level_o) begin
            ms_q <= '0;
        end else if (ms_q >= filt_ms_i) begin
            level_o <= sync2_q;
            ms_q <= '0;
        end else if (tick_i) begin
            ms_q <= ms_q + 1'b1;
        end
    end
endmodule

module dfd_dispatch
    import dfd_pkg::*;
#(
    parameter int TICK_CYC = FILT_TICK_CYC
)(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // terminals
    input wire logic [NUM_DI-1:0] di_pin_i,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // control core
    output dfd_ctrl_type ctrl_o,
    output logic [CNT_W-1:0] freq_setpoint_o
);
    logic [15:0] tick_cnt_q;
    logic tick_q;
    logic [NUM_DI-1:0] filt;
    logic [FC_W-1:0] func_sel_q [NUM_DI];
    logic [FILT_W-1:0] filt_ms_q;
    logic [CFG_W-1:0] cfg_q;
    logic [CNT_W-1:0] freq_pend_q;
    logic [CNT_W-1:0] evt_cnt_q;
    logic [CNT_W-1:0] len_cnt_q;
    logic evt_in_q;
    logic len_in_q;
    logic apply_in_q;
    logic ext_fault_q;
    logic ufault1_q;
    logic ufault2_q;
    logic [63:0] act;
    logic nc_open;
    logic apply_used;
    logic req;
    logic wr_ok;
    logic [31:0] rd_d;
    dfd_ctrl_type ctrl_d;

    // shared millisecond tick for all filters
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 16'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    generate
        for (genvar gi = 0; gi < NUM_DI; gi++) begin : g_filt
            dfd_input_filter u_filt (
                .clk_sys_i(clk_sys_i),
                .arst_n_i(arst_n_i),
                .pin_i(di_pin_i[gi]),
                .tick_i(tick_q),
                .filt_ms_i(filt_ms_q),
                .level_o(filt[gi])
            );
        end
    endgenerate

    // per-code OR of filtered terminals
    always_comb begin
        act = '0;
        nc_open = 1'b0;
        apply_used = 1'b0;
        for (int i = 0; i < NUM_DI; i++) begin
            if (func_sel_q[i] == FC_EXT_FAULT_NC) begin
                nc_open = nc_open | ~filt[i];
            end else if (func_sel_q[i] != FC_PULSE_IN || i == SIXTH_DI) begin
                act[func_sel_q[i]] = act[func_sel_q[i]] | filt[i];
            end
            if (func_sel_q[i] == FC_FREQ_APPLY) begin
                apply_used = 1'b1;
            end
        end
    end

    always_comb begin
        ctrl_d = '0;
        ctrl_d.swing_pause = act[FC_SWING_PAUSE];
        ctrl_d.torque_block = act[FC_TQ_BLOCK];
        ctrl_d.dc_brake_now = act[FC_DC_NOW];
        ctrl_d.ext_fault = ext_fault_q;
        ctrl_d.pid_reverse = cfg_q[CFG_PID_DIR] ^ act[FC_PID_REV];
        ctrl_d.keypad_stop = act[FC_KEY_STOP]
                             && cfg_q[CFG_SRC_LO +: 2] == SRC_KEYPAD;
        ctrl_d.cmd_source = cfg_q[CFG_SRC_LO +: 2];
        if (act[FC_SRC_SWAP]) begin
            if (cfg_q[CFG_SRC_LO +: 2] == SRC_TERMINAL) begin
                ctrl_d.cmd_source = SRC_COMM;
            end else if (cfg_q[CFG_SRC_LO +: 2] == SRC_COMM) begin
                ctrl_d.cmd_source = SRC_TERMINAL;
            end
        end
        ctrl_d.pid_int_freeze = act[FC_PID_INT_HOLD];
        ctrl_d.main_preset = act[FC_MAIN_PRESET];
        ctrl_d.aux_preset = act[FC_AUX_PRESET];
        ctrl_d.pid_gain2 = cfg_q[CFG_GAIN_BY_DI] & act[FC_PID_GAIN2];
        ctrl_d.user_fault1 = ufault1_q;
        ctrl_d.user_fault2 = ufault2_q;
        ctrl_d.fault_action = cfg_q[CFG_ACT_LO +: 2];
        ctrl_d.torque_mode = cfg_q[CFG_TQ_MODE] ^ act[FC_MODE_SWAP];
        ctrl_d.estop = act[FC_ESTOP] | ext_fault_q;
        ctrl_d.stop_decel4 = act[FC_STOP_DEC4];
        ctrl_d.decel_dc_brake = act[FC_DEC_DC];
        ctrl_d.run_time_clear = act[FC_RUNTIME_CLR];
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o <= ctrl_d;
        end
    end

    // edge detectors on filtered function levels
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_in_q <= 1'b0;
            len_in_q <= 1'b0;
            apply_in_q <= 1'b0;
        end else begin
            evt_in_q <= act[FC_CNT_IN];
            len_in_q <= act[FC_LEN_IN];
            apply_in_q <= act[FC_FREQ_APPLY];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_cnt_q <= '0;
        end else if (act[FC_CNT_CLR]) begin
            evt_cnt_q <= '0;
        end else if (act[FC_CNT_IN] && !evt_in_q) begin
            evt_cnt_q <= evt_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            len_cnt_q <= '0;
        end else if (act[FC_LEN_CLR]) begin
            len_cnt_q <= '0;
        end else if (act[FC_LEN_IN] && !len_in_q) begin
            len_cnt_q <= len_cnt_q + 1'b1;
        end
    end

    // without an apply terminal the setpoint follows at once
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_setpoint_o <= '0;
        end else if (!apply_used || (act[FC_FREQ_APPLY] && !apply_in_q)) begin
            freq_setpoint_o <= freq_pend_q;
        end
    end

    // bus: one wait cycle, then a single-cycle answer
    assign req = avs_read_i | avs_write_i;
    assign wr_ok = avs_write_i & ~avs_waitrequest_o;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
        end
    end

    // faults stay latched until written one to clear; a new fault wins
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_fault_q <= 1'b0;
            ufault1_q <= 1'b0;
            ufault2_q <= 1'b0;
        end else begin
            ext_fault_q <= nc_open | (ext_fault_q & ~(wr_ok && avs_address_i == REG_STATUS
                           && avs_writedata_i[ST_EXT_FAULT]));
            ufault1_q <= act[FC_USER_FAULT1] | (ufault1_q & ~(wr_ok
                         && avs_address_i == REG_STATUS && avs_writedata_i[ST_UFAULT1]));
            ufault2_q <= act[FC_USER_FAULT2] | (ufault2_q & ~(wr_ok
                         && avs_address_i == REG_STATUS && avs_writedata_i[ST_UFAULT2]));
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_DI; i++) begin
                func_sel_q[i] <= '0;
            end
            filt_ms_q <= FILT_DEFAULT_MS;
            cfg_q <= CFG_RESET;
            freq_pend_q <= '0;
        end else if (wr_ok) begin
            if (avs_address_i[ADDR_W-1:2] <= 4'(REG_FUNC_LAST_IDX)) begin
                func_sel_q[avs_address_i[4:2]] <= avs_writedata_i[FC_W-1:0];
            end
            if (avs_address_i == REG_FILTER) begin
                // whole word compared, so large values clamp instead of wrapping
                filt_ms_q <= (avs_writedata_i > 32'(FILT_MAX_MS)) ? FILT_MAX_MS
                             : avs_writedata_i[FILT_W-1:0];
            end
            if (avs_address_i == REG_CONFIG) begin
                cfg_q <= avs_writedata_i[CFG_W-1:0];
            end
            if (avs_address_i == REG_FREQ_PEND) begin
                freq_pend_q <= avs_writedata_i[CNT_W-1:0];
            end
        end
    end

    always_comb begin
        rd_d = '0;
        if (avs_address_i[ADDR_W-1:2] <= 4'(REG_FUNC_LAST_IDX)) begin
            rd_d[FC_W-1:0] = func_sel_q[avs_address_i[4:2]];
        end else begin
            unique case (avs_address_i)
                REG_FILTER: rd_d[FILT_W-1:0] = filt_ms_q;
                REG_CONFIG: rd_d[CFG_W-1:0] = cfg_q;
                REG_FREQ_PEND: rd_d[CNT_W-1:0] = freq_pend_q;
                REG_FREQ_EFF: rd_d[CNT_W-1:0] = freq_setpoint_o;
                REG_EVT_COUNT: rd_d[CNT_W-1:0] = evt_cnt_q;
                REG_LEN_COUNT: rd_d[CNT_W-1:0] = len_cnt_q;
                REG_STATUS: begin
                    rd_d[NUM_DI-1:0] = filt;
                    rd_d[ST_EXT_FAULT] = ext_fault_q;
                    rd_d[ST_UFAULT1] = ufault1_q;
                    rd_d[ST_UFAULT2] = ufault2_q;
                end
                default: rd_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_d;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    cnt_clear_a: assert property (act[FC_CNT_CLR] |=> evt_cnt_q == '0)
        else $error("event counter not cleared");
    cnt_step_a: assert property (act[FC_CNT_IN] && !evt_in_q && !act[FC_CNT_CLR]
        |=> evt_cnt_q == $past(evt_cnt_q) + 1'b1)
        else $error("event counter did not advance");
    len_clear_a: assert property (act[FC_LEN_CLR] |=> len_cnt_q == '0)
        else $error("length not cleared");
    len_step_a: assert property (act[FC_LEN_IN] && !len_in_q && !act[FC_LEN_CLR]
        |=> len_cnt_q == $past(len_cnt_q) + 1'b1)
        else $error("length did not advance");
    pid_dir_a: assert property (ctrl_o.pid_reverse == $past(cfg_q[CFG_PID_DIR]
        ^ act[FC_PID_REV]))
        else $error("pid direction wrong");
    mode_swap_a: assert property (act[FC_MODE_SWAP]
        |=> ctrl_o.torque_mode != $past(cfg_q[CFG_TQ_MODE]))
        else $error("mode not swapped");
    // the fault latch sits one stage before the output register, hence the extra cycle
    ext_fault_a: assert property (nc_open |=> ##1 (ctrl_o.ext_fault && ctrl_o.estop))
        else $error("external fault not flagged");
    freq_hold_a: assert property (apply_used && !act[FC_FREQ_APPLY]
        && $stable(apply_used) |=> $stable(freq_setpoint_o))
        else $error("setpoint applied without terminal");
    freq_apply_a: assert property (act[FC_FREQ_APPLY] && !apply_in_q
        |=> freq_setpoint_o == $past(freq_pend_q))
        else $error("pending setpoint not applied");
    src_swap_a: assert property (act[FC_SRC_SWAP]
        && cfg_q[CFG_SRC_LO +: 2] == SRC_TERMINAL && $stable(cfg_q)
        |=> ctrl_o.cmd_source == SRC_COMM)
        else $error("command source not swapped");
    dc_now_a: assert property (act[FC_DC_NOW]
        |=> ctrl_o.dc_brake_now)
        else $error("dc braking not entered");
    key_stop_a: assert property (act[FC_KEY_STOP]
        && cfg_q[CFG_SRC_LO +: 2] == SRC_KEYPAD |=> ctrl_o.keypad_stop)
        else $error("keypad stop missing");
    user_fault_a: assert property (act[FC_USER_FAULT1]
        |=> ##1 ctrl_o.user_fault1)
        else $error("user fault not flagged");
    run_clear_a: assert property (act[FC_RUNTIME_CLR]
        |=> ctrl_o.run_time_clear)
        else $error("running time clear missing");
    estop_a: assert property (act[FC_ESTOP] |=> ctrl_o.estop)
        else $error("emergency stop missing");
    bus_wait_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o ##1
        avs_waitrequest_o)
        else $error("bus answer timing wrong");
endmodule

/* logic/dfd_pkg.sv */
// constants, register map and carrier types of the digital input function dispatch
package dfd_pkg;
    localparam int NUM_DI = 6;
    localparam int SIXTH_DI = 5;
    localparam int FC_W = 6;
    localparam int CNT_W = 16;
    localparam int FILT_W = 10;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILT_TICK_NS = 1000000;
    localparam int FILT_TICK_CYC = FILT_TICK_NS / CLK_PERIOD_NS;
    localparam logic [FILT_W-1:0] FILT_DEFAULT_MS = 10'h00a;
    localparam logic [FILT_W-1:0] FILT_MAX_MS = 10'h3e8;
    // function codes
    localparam logic [FC_W-1:0] FC_SWING_PAUSE = 6'h18;
    localparam logic [FC_W-1:0] FC_CNT_IN = 6'h19;
    localparam logic [FC_W-1:0] FC_CNT_CLR = 6'h1a;
    localparam logic [FC_W-1:0] FC_LEN_IN = 6'h1b;
    localparam logic [FC_W-1:0] FC_LEN_CLR = 6'h1c;
    localparam logic [FC_W-1:0] FC_TQ_BLOCK = 6'h1d;
    localparam logic [FC_W-1:0] FC_PULSE_IN = 6'h1e;
    localparam logic [FC_W-1:0] FC_DC_NOW = 6'h20;
    localparam logic [FC_W-1:0] FC_EXT_FAULT_NC = 6'h21;
    localparam logic [FC_W-1:0] FC_FREQ_APPLY = 6'h22;
    localparam logic [FC_W-1:0] FC_PID_REV = 6'h23;
    localparam logic [FC_W-1:0] FC_KEY_STOP = 6'h24;
    localparam logic [FC_W-1:0] FC_SRC_SWAP = 6'h25;
    localparam logic [FC_W-1:0] FC_PID_INT_HOLD = 6'h26;
    localparam logic [FC_W-1:0] FC_MAIN_PRESET = 6'h27;
    localparam logic [FC_W-1:0] FC_AUX_PRESET = 6'h28;
    localparam logic [FC_W-1:0] FC_PID_GAIN2 = 6'h2b;
    localparam logic [FC_W-1:0] FC_USER_FAULT1 = 6'h2c;
    localparam logic [FC_W-1:0] FC_USER_FAULT2 = 6'h2d;
    localparam logic [FC_W-1:0] FC_MODE_SWAP = 6'h2e;
    localparam logic [FC_W-1:0] FC_ESTOP = 6'h2f;
    localparam logic [FC_W-1:0] FC_STOP_DEC4 = 6'h30;
    localparam logic [FC_W-1:0] FC_DEC_DC = 6'h31;
    localparam logic [FC_W-1:0] FC_RUNTIME_CLR = 6'h32;
    // register map, byte addresses
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] REG_FUNC_SEL0 = 6'h00;
    localparam logic [ADDR_W-1:0] REG_FILTER = 6'h18;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 6'h1c;
    localparam logic [ADDR_W-1:0] REG_FREQ_PEND = 6'h20;
    localparam logic [ADDR_W-1:0] REG_FREQ_EFF = 6'h24;
    localparam logic [ADDR_W-1:0] REG_EVT_COUNT = 6'h28;
    localparam logic [ADDR_W-1:0] REG_LEN_COUNT = 6'h2c;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h30;
    localparam int REG_FUNC_LAST_IDX = 5;
    // config fields
    localparam int CFG_PID_DIR = 0;
    localparam int CFG_SRC_LO = 1;
    localparam int CFG_GAIN_BY_DI = 3;
    localparam int CFG_TQ_MODE = 4;
    localparam int CFG_ACT_LO = 5;
    localparam int CFG_W = 7;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
    // status fields
    localparam int ST_EXT_FAULT = 8;
    localparam int ST_UFAULT1 = 9;
    localparam int ST_UFAULT2 = 10;
    // command sources
    localparam logic [1:0] SRC_KEYPAD = 2'h0;
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam logic [1:0] SRC_COMM = 2'h2;

    typedef struct packed {
        logic swing_pause;
        logic torque_block;
        logic dc_brake_now;
        logic ext_fault;
        logic pid_reverse;
        logic keypad_stop;
        logic [1:0] cmd_source;
        logic pid_int_freeze;
        logic main_preset;
        logic aux_preset;
        logic pid_gain2;
        logic user_fault1;
        logic user_fault2;
        logic [1:0] fault_action;
        logic torque_mode;
        logic estop;
        logic stop_decel4;
        logic decel_dc_brake;
        logic run_time_clear;
    } dfd_ctrl_type;
endpackage

/* sim/dfd_switch_model.sv */
// external contacts driving the terminal pins, with optional contact bounce
`timescale 1ns/100ps
module dfd_switch_model
    import dfd_pkg::*;
#(
    parameter int BOUNCE_CYC = 6
)(
    // clock
    input wire logic clk_sys_i,
    // commanded contact state
    input wire logic [NUM_DI-1:0] target_i,
    input wire logic bounce_i,
    // terminal levels
    output logic [NUM_DI-1:0] pin_o
);
    logic [NUM_DI-1:0] last_q = '0;
    logic [NUM_DI-1:0] chg_q = '0;
    int cnt_q = 0;
    initial pin_o = '0;
    // chatter toggles every cycle, so only the input filter can hide it
    always @(posedge clk_sys_i) begin
        last_q <= target_i;
        if (bounce_i && target_i != last_q) begin
            cnt_q <= BOUNCE_CYC;
            chg_q <= target_i ^ last_q;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
        pin_o <= (cnt_q > 0) ? (pin_o ^ chg_q) : target_i;
    end
endmodule

/* sim/testbench.sv */
// self-checking testbench of the digital input function dispatch
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    import dfd_pkg::*;
    localparam int TICK = 10;
    localparam int LAT = 6;
    localparam logic [FC_W-1:0] LVL [12] = '{FC_SWING_PAUSE, FC_TQ_BLOCK, FC_DC_NOW,
        FC_PID_REV, FC_PID_INT_HOLD, FC_MAIN_PRESET, FC_AUX_PRESET, FC_ESTOP, FC_STOP_DEC4,
        FC_DEC_DC, FC_RUNTIME_CLR, FC_KEY_STOP};
    // config, code, value while active, value while idle
    localparam logic [31:0] CFG_TAB [8] = '{32'h02250201, 32'h04250102, 32'h00250000,
        32'h02240000, 32'h082b0100, 32'h002b0000, 32'h102e0001, 32'h002e0100};
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [NUM_DI-1:0] tgt = '0;
    logic bounce = 1'b0;
    logic [NUM_DI-1:0] di_pin;
    logic [ADDR_W-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic wait_req;
    dfd_ctrl_type ctrl;
    logic [CNT_W-1:0] setpoint;
    logic snap_q = 1'b0;
    logic [FC_W-1:0] snap_code = '0;
    logic [31:0] exp_q[$];
    logic [31:0] got;
    logic [31:0] rnd = 32'hb39c9e9a;
    logic [15:0] v1;
    int miscompares = 0;
    int n_compared = 0;

    dfd_switch_model i_sw (.clk_sys_i(clk_sys_i), .target_i(tgt), .bounce_i(bounce),
        .pin_o(di_pin));
    dfd_dispatch #(.TICK_CYC(TICK)) i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .di_pin_i(di_pin), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .ctrl_o(ctrl), .freq_setpoint_o(setpoint));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // the field of the control word that a function code drives
    function automatic logic [31:0] fld(input dfd_ctrl_type c, input logic [FC_W-1:0] code);
        case (code)
            FC_SWING_PAUSE: return 32'(c.swing_pause);
            FC_TQ_BLOCK: return 32'(c.torque_block);
            FC_DC_NOW: return 32'(c.dc_brake_now);
            FC_PID_REV: return 32'(c.pid_reverse);
            FC_PID_INT_HOLD: return 32'(c.pid_int_freeze);
            FC_MAIN_PRESET: return 32'(c.main_preset);
            FC_AUX_PRESET: return 32'(c.aux_preset);
            FC_ESTOP: return 32'(c.estop);
            FC_STOP_DEC4: return 32'(c.stop_decel4);
            FC_DEC_DC: return 32'(c.decel_dc_brake);
            FC_RUNTIME_CLR: return 32'(c.run_time_clear);
            FC_KEY_STOP: return 32'(c.keypad_stop);
            FC_SRC_SWAP: return 32'(c.cmd_source);
            FC_PID_GAIN2: return 32'(c.pid_gain2);
            FC_MODE_SWAP: return 32'(c.torque_mode);
            FC_EXT_FAULT_NC: return 32'({c.estop, c.ext_fault});
            FC_USER_FAULT1: return 32'({c.fault_action, c.user_fault1});
            FC_USER_FAULT2: return 32'(c.user_fault2);
            FC_FREQ_APPLY: return 32'(setpoint);
            default: return 32'(c);
        endcase
    endfunction

    task automatic give_verdict();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_req !== 1'b0) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rreg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic sel(input int k, input logic [FC_W-1:0] code);
        wreg(ADDR_W'(int'(REG_FUNC_SEL0) + 4 * k), 32'(code));
    endtask

    // the note gives pin to control word as five edges, one more through the model; dfd_dispatch takes four
    task automatic pins(input logic [NUM_DI-1:0] v);
        @(posedge clk_sys_i);
        tgt <= v;
        repeat (LAT) @(posedge clk_sys_i);
    endtask

    task automatic expect_ctrl(input logic [FC_W-1:0] code, input logic [31:0] e);
        @(posedge clk_sys_i);
        exp_q.push_back(e);
        snap_code <= code;
        snap_q <= 1'b1;
        @(posedge clk_sys_i);
        snap_q <= 1'b0;
    endtask

    task automatic run_case(input logic [CFG_W-1:0] cfg, input logic [FC_W-1:0] code,
        input logic [31:0] on, input logic [31:0] off);
        wreg(REG_CONFIG, 32'(cfg));
        sel(0, code);
        pins(6'h01);
        expect_ctrl(code, on);
        pins(6'h00);
        expect_ctrl(code, off);
        sel(0, 6'h00);
    endtask

    task automatic count_test(input logic [FC_W-1:0] cin, input logic [FC_W-1:0] cclr,
        input logic [ADDR_W-1:0] a);
        int n;
        rnd = lfsr(rnd);
        n = 1 + int'(rnd[3:0]);
        sel(2, cin);
        sel(3, cclr);
        for (int i = 0; i < n; i++) begin
            pins(6'h04);
            pins(6'h00);
        end
        rreg(a, 32'(n));
        pins(6'h0c);
        pins(6'h00);
        rreg(a, 32'h0);
        sel(2, 6'h00);
        sel(3, 6'h00);
    endtask

    // results are taken in the order they were noted
    always @(posedge clk_sys_i) begin
        if ((rd && wait_req === 1'b0) || snap_q) begin
            got = snap_q ? fld(ctrl, snap_code) : rdata;
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("wrong value at %0t: unexpected result %h", $time, got);
            end else begin
                `CHK(got, exp_q.pop_front())
            end
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rreg(REG_FILTER, 32'(FILT_DEFAULT_MS));
        rreg(REG_CONFIG, 32'h0);
        rreg(6'h3c, 32'h0);
        expect_ctrl(6'h00, 32'h0);
        wreg(REG_FILTER, 32'h0);
        foreach (LVL[i]) run_case(7'h00, LVL[i], 32'h1, 32'h0);
        foreach (CFG_TAB[i]) run_case(CFG_TAB[i][30:24], CFG_TAB[i][21:16],
            32'(CFG_TAB[i][15:8]), 32'(CFG_TAB[i][7:0]));
        wreg(REG_CONFIG, 32'h0);
        sel(0, FC_ESTOP);
        sel(1, FC_ESTOP);
        pins(6'h02);
        expect_ctrl(FC_ESTOP, 32'h1);
        pins(6'h00);
        sel(1, 6'h00);
        sel(0, FC_PULSE_IN);
        sel(1, 6'h1f);
        sel(2, 6'h29);
        sel(3, 6'h2a);
        sel(SIXTH_DI, FC_PULSE_IN);
        pins(6'h2f);
        expect_ctrl(6'h00, 32'h0);
        rreg(REG_STATUS, 32'h2f);
        pins(6'h00);
        for (int k = 0; k < NUM_DI; k++) sel(k, 6'h00);
        count_test(FC_CNT_IN, FC_CNT_CLR, REG_EVT_COUNT);
        count_test(FC_LEN_IN, FC_LEN_CLR, REG_LEN_COUNT);
        rnd = lfsr(rnd);
        v1 = rnd[15:0];
        wreg(REG_FREQ_PEND, 32'(v1));
        rreg(REG_FREQ_EFF, 32'(v1));
        expect_ctrl(FC_FREQ_APPLY, 32'(v1));
        sel(4, FC_FREQ_APPLY);
        rnd = lfsr(rnd);
        wreg(REG_FREQ_PEND, 32'(rnd[15:0]));
        rreg(REG_FREQ_EFF, 32'(v1));
        expect_ctrl(FC_FREQ_APPLY, 32'(v1));
        pins(6'h10);
        rreg(REG_FREQ_EFF, 32'(rnd[15:0]));
        expect_ctrl(FC_FREQ_APPLY, 32'(rnd[15:0]));
        sel(4, 6'h00);
        // the fault contact is closed before it is assigned, else it latches at once
        pins(6'h02);
        sel(1, FC_EXT_FAULT_NC);
        expect_ctrl(FC_EXT_FAULT_NC, 32'h0);
        pins(6'h00);
        expect_ctrl(FC_EXT_FAULT_NC, 32'h3);
        pins(6'h02);
        rreg(REG_STATUS, 32'h102);
        wreg(REG_STATUS, 32'h100);
        rreg(REG_STATUS, 32'h002);
        sel(1, 6'h00);
        wreg(REG_CONFIG, 32'h60);
        sel(0, FC_USER_FAULT1);
        sel(2, FC_USER_FAULT2);
        pins(6'h01);
        pins(6'h00);
        expect_ctrl(FC_USER_FAULT1, 32'h7);
        pins(6'h04);
        pins(6'h00);
        expect_ctrl(FC_USER_FAULT2, 32'h1);
        rreg(REG_STATUS, 32'h600);
        wreg(REG_STATUS, 32'h600);
        rreg(REG_STATUS, 32'h0);
        sel(2, 6'h00);
        wreg(REG_FILTER, 32'h7d0);
        rreg(REG_FILTER, 32'(FILT_MAX_MS));
        wreg(REG_FILTER, 32'h2);
        sel(0, FC_ESTOP);
        @(posedge clk_sys_i);
        bounce <= 1'b1;
        tgt <= 6'h01;
        repeat (3) @(posedge clk_sys_i);
        tgt <= 6'h00;
        repeat (60) @(posedge clk_sys_i);
        expect_ctrl(FC_ESTOP, 32'h0);
        bounce <= 1'b0;
        tgt <= 6'h01;
        repeat (8) @(posedge clk_sys_i);
        expect_ctrl(FC_ESTOP, 32'h0);
        repeat (40) @(posedge clk_sys_i);
        expect_ctrl(FC_ESTOP, 32'h1);
        give_verdict();
    end
endmodule
